// ==== ssmd_pkg.sv ====
// Constants, types and record layout for the safing monitor decoder.
// Shared by the decoder module and by the bench around it.
package ssmd_pkg;
	localparam int NREC      = 16;  // Number of safing records
	localparam int NARM      = 4;   // Internal arming signals
	localparam int NCS       = 5;   // Monitored chip selects
	localparam int NCOMB     = 12;  // Records 0..11 form combine pairs
	localparam int WORD_W    = 32;  // Longest monitored word
	localparam int HALF_W    = 16;  // Short record width
	localparam int CNT_W     = 8;   // Link bit counter width
	localparam int DWELL_W   = 8;   // Dwell field width
	localparam int CSSEL_W   = 3;   // Chip-select index width
	localparam int ARMSEL_W  = 2;   // Arm-signal index width
	localparam logic [CNT_W-1:0] LONG_FRAME_MIN = 8'h20; // Frames of 32 bits or more

	// Clock and dwell tick timing
	localparam int CLK_PERIOD_NS  = 50;
	localparam int DWELL_TICK_NS  = 1000;
	localparam int DWELL_TICK_CYC = (DWELL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Out-of-range limits of 8-bit and 10-bit sensor data
	localparam logic signed [31:0] RANGE8_LIMIT  = 32'sh0000_0078;
	localparam logic signed [31:0] RANGE10_LIMIT = 32'sh0000_01e0;

	// Safing state machine states seen by the decoder
	typedef enum logic [1:0]
	{
		SSM_INIT   = 2'b00,
		SSM_DIAG   = 2'b01,
		SSM_SAFING = 2'b10,
		SSM_OTHER  = 2'b11
	} ssmd_ssm_t;

	// Configuration of one safing record
	typedef struct packed
	{
		logic [31:0]          req_mask;
		logic [31:0]          req_target;
		logic [31:0]          rsp_mask;
		logic [31:0]          rsp_target;
		logic [31:0]          record_extract_mask;
		logic signed [31:0]   event_threshold;
		logic                 long_rec;
		logic                 in_frame;
		logic [CSSEL_W-1:0]   cs_sel;
		logic [ARMSEL_W-1:0]  arm_signal_select;
		logic [DWELL_W-1:0]   dwell;
		logic                 comb;
		logic                 range_check_enable;
		logic                 range_check_select;
		logic                 long_frame_field_select;
	} ssmd_rec_cfg_t;
endpackage

// ==== ssmd_monitor.sv ====
// Passive safing monitor: decodes sensor-bus frames into 16 safing records,
// compares the extracted data and drives four internal arming signals.
// Assumes SPI sampled on rising link clock, MSB first, chip selects low-active,
// and an inter-frame gap of at least four system clocks.
`timescale 1ns/1ps
`default_nettype none

module ssmd_monitor #(
	parameter int DWELL_TICK = ssmd_pkg::DWELL_TICK_CYC
)(
	input  wire logic                                     clk,
	input  wire logic                                     arst_n,
	input  wire logic                                     spi_link_clk,
	input  wire logic                                     sensor_bus_chip_select_n,
	input  wire logic [ssmd_pkg::NCS-2:0]                 extra_monitor_chip_select_n,
	input  wire logic                                     monitored_request_line,
	input  wire logic                                     monitored_sensor_reply_line,
	input  wire ssmd_pkg::ssmd_ssm_t                      safing_state_machine_state,
	input  wire logic                                     safing_state_machine_reset,
	input  wire logic                                     sample_sync_event,
	input  wire ssmd_pkg::ssmd_rec_cfg_t [ssmd_pkg::NREC-1:0] rec_cfg_in,
	input  wire logic [ssmd_pkg::NREC-1:0]                rec_enable_in,
	input  wire logic                                     external_engine_in,
	input  wire logic                                     compare_done_read,
	output logic [ssmd_pkg::NREC-1:0]                     compare_done_register,
	output logic [ssmd_pkg::NREC-1:0]                     positive_arm_result,
	output logic [ssmd_pkg::NREC-1:0]                     negative_arm_result,
	output logic [ssmd_pkg::NREC-1:0]                     record_armed,
	output logic [ssmd_pkg::NARM-1:0]                     internal_arm_signal,
	output logic                                          external_engine_sel
);
	import ssmd_pkg::*;

	// Link-domain shift registers and bit counter
	logic [WORD_W-1:0]  req_sr_reg;
	logic [WORD_W-1:0]  rsp_sr_reg;
	logic [CNT_W-1:0]   bit_cnt_reg;
	logic [NCS-1:0]     cs_n_pins;
	logic               frame_open;

	// System-domain frame capture
	logic [NCS-1:0]     cs_m1_reg;
	logic [NCS-1:0]     cs_m2_reg;
	logic [NCS-1:0]     cs_m3_reg;
	logic [NCS-1:0]     cs_rise;
	logic [CSSEL_W-1:0] rise_idx;
	logic [WORD_W-1:0]  req_w_reg;
	logic [WORD_W-1:0]  rsp_w_reg;
	logic [CNT_W-1:0]   cnt_prev_reg;
	logic [CNT_W-1:0]   fr_len_reg;
	logic [CSSEL_W-1:0] fr_cs_reg;
	logic               fr_vld_reg;
	logic               safing;

	// Record state
	ssmd_rec_cfg_t      cfg_reg [NREC];
	logic signed [31:0] data_reg [NREC];
	logic [DWELL_W-1:0] dwell_cnt_reg [NREC];
	logic [NREC-1:0]    en_reg;
	logic [NREC-1:0]    cap_reg;
	logic [NREC-1:0]    pend_reg;
	logic [NREC-1:0]    hit;
	logic [NREC-1:0]    eval;
	logic [NREC-1:0]    arm_ev;
	logic [NREC-1:0]    pos_ev;
	logic [NREC-1:0]    neg_ev;
	logic [15:0]        tick_cnt_reg;
	logic               tick;

	// Position of the lowest set bit of a mask, used to right-justify
	function automatic logic [4:0] ssmd_trailing_zeros(input logic [31:0] m);
		logic [4:0] n;
		logic       f;
		n = 5'h00;
		f = 1'b0;
		for (int b = 0; b < WORD_W; b++)
		begin
			if (!f && m[b])
			begin
				n = 5'(b);
				f = 1'b1;
			end
		end
		return n;
	endfunction

	assign cs_n_pins  = {extra_monitor_chip_select_n, sensor_bus_chip_select_n};
	assign frame_open = ~&cs_n_pins;
	assign safing     = (safing_state_machine_state == SSM_SAFING);

	// Link side: shift both lines while any monitored chip select is low
	always_ff @(posedge spi_link_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			req_sr_reg  <= 32'h0000_0000;
			rsp_sr_reg  <= 32'h0000_0000;
			bit_cnt_reg <= 8'h00;
		end
		else if (frame_open)
		begin
			req_sr_reg  <= {req_sr_reg[WORD_W-2:0], monitored_request_line};
			rsp_sr_reg  <= {rsp_sr_reg[WORD_W-2:0], monitored_sensor_reply_line};
			bit_cnt_reg <= bit_cnt_reg + 8'h01;
		end
	end

	// Chip-select synchroniser and end-of-frame edge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cs_m1_reg <= 5'h1f;
			cs_m2_reg <= 5'h1f;
			cs_m3_reg <= 5'h1f;
		end
		else
		begin
			cs_m1_reg <= cs_n_pins;
			cs_m2_reg <= cs_m1_reg;
			cs_m3_reg <= cs_m2_reg;
		end
	end

	assign cs_rise = cs_m2_reg & ~cs_m3_reg;

	// Lowest chip select that just closed its frame
	always_comb
	begin
		rise_idx = 3'h0;
		for (int c = NCS - 1; c >= 0; c--)
		begin
			if (cs_rise[c])
			begin
				rise_idx = 3'(c);
			end
		end
	end

	// Words are still while the link clock stands in the gap, so take them here
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			req_w_reg    <= 32'h0000_0000;
			rsp_w_reg    <= 32'h0000_0000;
			cnt_prev_reg <= 8'h00;
			fr_len_reg   <= 8'h00;
			fr_cs_reg    <= 3'h0;
			fr_vld_reg   <= 1'b0;
		end
		else
		begin
			fr_vld_reg <= |cs_rise;
			if (|cs_rise)
			begin
				req_w_reg    <= req_sr_reg;
				rsp_w_reg    <= rsp_sr_reg;
				fr_len_reg   <= bit_cnt_reg - cnt_prev_reg;
				cnt_prev_reg <= bit_cnt_reg;
				fr_cs_reg    <= rise_idx;
			end
		end
	end

	// Engine selection is taken only in the initialisation state
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			external_engine_sel <= 1'b0;
		end
		else if (safing_state_machine_state == SSM_INIT)
		begin
			external_engine_sel <= external_engine_in;
		end
	end

	// Dwell time base
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt_reg <= 16'h0000;
		end
		else if (tick)
		begin
			tick_cnt_reg <= 16'h0000;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
		end
	end

	assign tick = (tick_cnt_reg == 16'(DWELL_TICK - 1));

	// One slice per record; every record sees every frame on its own
	for (genvar i = 0; i < NREC; i++)
	begin : g_rec
		localparam int P = i ^ 1;
		logic [HALF_W-1:0]  w16;
		logic [WORD_W-1:0]  w;
		logic [WORD_W-1:0]  m;
		logic [WORD_W-1:0]  j;
		logic signed [31:0] sx;
		logic signed [31:0] lim;
		logic signed [31:0] val;
		logic               in_rng;
		logic               req_hit;
		logic               rsp_hit;
		logic               cs_hit;
		logic               comb_on;

		// Decode and extraction
		assign req_hit = ((req_w_reg & cfg_reg[i].req_mask) == cfg_reg[i].req_target);
		assign rsp_hit = ((rsp_w_reg & cfg_reg[i].rsp_mask) == cfg_reg[i].rsp_target);
		assign cs_hit  = fr_vld_reg && (fr_cs_reg == cfg_reg[i].cs_sel);
		assign w16 = (fr_len_reg >= LONG_FRAME_MIN && cfg_reg[i].long_frame_field_select)
			? rsp_w_reg[31:16] : rsp_w_reg[15:0];
		assign w = cfg_reg[i].long_rec ? rsp_w_reg : {16'h0000, w16};
		assign m = cfg_reg[i].long_rec ? cfg_reg[i].record_extract_mask
			: {16'h0000, cfg_reg[i].record_extract_mask[15:0]};
		assign j  = (w & m) >> ssmd_trailing_zeros(m);
		assign sx = cfg_reg[i].long_rec ? $signed(j) : $signed({{16{j[15]}}, j[15:0]});

		// Out-of-range check of the extracted sample
		assign lim    = cfg_reg[i].range_check_select ? RANGE10_LIMIT : RANGE8_LIMIT;
		assign in_rng = !cfg_reg[i].range_check_enable || (sx <= lim && sx >= -lim);

		// Capture only the first valid match while the record is idle
		assign hit[i] = cs_hit && safing && en_reg[i] && !cap_reg[i]
			&& !compare_done_register[i] && rsp_hit && in_rng
			&& (cfg_reg[i].in_frame ? req_hit : pend_reg[i]);

		// Combine pairs: the even record compares the sum, the odd one even minus odd
		assign comb_on = (i < NCOMB) && cfg_reg[i].comb && !cfg_reg[i].long_rec;
		if (i % 2 == 0)
		begin : g_even
			assign val = comb_on ? 32'(data_reg[i] + data_reg[P]) : data_reg[i];
		end
		else
		begin : g_odd
			assign val = comb_on ? 32'(data_reg[P] - data_reg[i]) : data_reg[i];
		end
		assign eval[i] = cap_reg[i] && !compare_done_register[i] && safing
			&& (!comb_on || cap_reg[P]);
		assign pos_ev[i] = val > cfg_reg[i].event_threshold;
		assign neg_ev[i] = val < -cfg_reg[i].event_threshold;
		assign arm_ev[i] = eval[i] && (pos_ev[i] || neg_ev[i]);

		// Settings load in diag only; cleared by the safing reset
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				cfg_reg[i] <= '0;
			end
			else if (safing_state_machine_reset)
			begin
				cfg_reg[i] <= '0;
			end
			else if (safing_state_machine_state == SSM_DIAG)
			begin
				cfg_reg[i] <= rec_cfg_in[i];
			end
		end

		// Enable follows the sample sync event
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				en_reg[i] <= 1'b0;
			end
			else if (safing_state_machine_reset)
			begin
				en_reg[i] <= 1'b0;
			end
			else if (sample_sync_event)
			begin
				en_reg[i] <= rec_enable_in[i];
			end
		end

		// Request seen on a frame arms the reply check of the next one
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				pend_reg[i] <= 1'b0;
			end
			else if (safing_state_machine_reset)
			begin
				pend_reg[i] <= 1'b0;
			end
			else if (cs_hit)
			begin
				pend_reg[i] <= req_hit;
			end
		end

		// Sample capture; freed again when the done flag is read away
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				cap_reg[i]  <= 1'b0;
				data_reg[i] <= 32'sh0000_0000;
			end
			else if (safing_state_machine_reset)
			begin
				cap_reg[i]  <= 1'b0;
				data_reg[i] <= 32'sh0000_0000;
			end
			else if (hit[i])
			begin
				cap_reg[i]  <= 1'b1;
				data_reg[i] <= sx;
			end
			else if (compare_done_read && compare_done_register[i] && !eval[i])
			begin
				cap_reg[i] <= 1'b0;
			end
		end

		// Done flag: set by evaluation, cleared by read, set wins
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				compare_done_register[i] <= 1'b0;
			end
			else if (safing_state_machine_reset)
			begin
				compare_done_register[i] <= 1'b0;
			end
			else if (eval[i])
			begin
				compare_done_register[i] <= 1'b1;
			end
			else if (compare_done_read)
			begin
				compare_done_register[i] <= 1'b0;
			end
		end

		// Latest comparison result per direction
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				positive_arm_result[i] <= 1'b0;
				negative_arm_result[i] <= 1'b0;
			end
			else if (safing_state_machine_reset)
			begin
				positive_arm_result[i] <= 1'b0;
				negative_arm_result[i] <= 1'b0;
			end
			else if (eval[i])
			begin
				positive_arm_result[i] <= pos_ev[i];
				negative_arm_result[i] <= neg_ev[i];
			end
		end

		// Dwell stretch: only ever extended, runs on regardless of enable
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				dwell_cnt_reg[i] <= 8'h00;
			end
			else if (safing_state_machine_reset)
			begin
				dwell_cnt_reg[i] <= 8'h00;
			end
			else if (arm_ev[i] && cfg_reg[i].dwell > dwell_cnt_reg[i])
			begin
				dwell_cnt_reg[i] <= cfg_reg[i].dwell;
			end
			else if (tick && dwell_cnt_reg[i] != 8'h00)
			begin
				dwell_cnt_reg[i] <= dwell_cnt_reg[i] - 8'h01;
			end
		end

		// Armed while the event is fresh or its dwell is running
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				record_armed[i] <= 1'b0;
			end
			else
			begin
				record_armed[i] <= !safing_state_machine_reset
					&& (arm_ev[i] || dwell_cnt_reg[i] > 8'h01
					|| (dwell_cnt_reg[i] == 8'h01 && !tick));
			end
		end
	end

	// Arm signals: OR of the records mapped onto each, held low while the external engine is selected
	for (genvar k = 0; k < NARM; k++)
	begin : g_arm
		logic [NREC-1:0] sel;
		for (genvar r = 0; r < NREC; r++)
		begin : g_sel
			assign sel[r] = (cfg_reg[r].arm_signal_select == ARMSEL_W'(k));
		end
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				internal_arm_signal[k] <= 1'b0;
			end
			else
			begin
				internal_arm_signal[k] <= !external_engine_sel && |(sel & record_armed);
			end
		end
	end

endmodule

`default_nettype wire

// ==== ssmd_chk.sv ====
// Port checker for the safing monitor decoder, bound to its top module.
// Assumes rec_cfg_in is held constant once the records have been loaded.
`timescale 1ns/1ps
`default_nettype none

module ssmd_chk #(
	parameter int DWELL_TICK = ssmd_pkg::DWELL_TICK_CYC
)(
	input wire logic                                         clk,
	input wire logic                                         arst_n,
	input wire ssmd_pkg::ssmd_ssm_t                          safing_state_machine_state,
	input wire logic                                         safing_state_machine_reset,
	input wire ssmd_pkg::ssmd_rec_cfg_t [ssmd_pkg::NREC-1:0] rec_cfg_in,
	input wire logic                                         external_engine_in,
	input wire logic                                         compare_done_read,
	input wire logic [ssmd_pkg::NREC-1:0]                    compare_done_register,
	input wire logic [ssmd_pkg::NREC-1:0]                    positive_arm_result,
	input wire logic [ssmd_pkg::NREC-1:0]                    negative_arm_result,
	input wire logic [ssmd_pkg::NREC-1:0]                    record_armed,
	input wire logic [ssmd_pkg::NARM-1:0]                    internal_arm_signal,
	input wire logic                                         external_engine_sel
);
	import ssmd_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Arm signals expected from a set of armed records
	function automatic logic [NARM-1:0] arm_map(input logic [NREC-1:0] a);
		arm_map = '0;
		for (int i = 0; i < NREC; i++)
			if (a[i])
				arm_map[rec_cfg_in[i].arm_signal_select] = 1'b1;
	endfunction

	// Flags and results around reads, resets and states
	done_clear_a: assert property (compare_done_read |=>
		(compare_done_register & $past(compare_done_register)) == '0)
		else $error("done flag survived a read");
	no_proc_a: assert property ((safing_state_machine_state != SSM_SAFING)[*5] |=>
		(compare_done_register & ~$past(compare_done_register)) == '0)
		else $error("record evaluated outside safing");
	sreset_clear_a: assert property (safing_state_machine_reset |=>
		compare_done_register == '0 && positive_arm_result == '0 && negative_arm_result == '0)
		else $error("results kept over safing reset");
	arm_drop_a: assert property (safing_state_machine_reset |->
		##1 record_armed == '0 ##1 internal_arm_signal == '0)
		else $error("arming kept over safing reset");
	ext_force_a: assert property (external_engine_sel && $past(external_engine_sel) |->
		internal_arm_signal == '0)
		else $error("internal arm with external engine");
	ext_latch_a: assert property (safing_state_machine_state == SSM_INIT |=>
		external_engine_sel == $past(external_engine_in))
		else $error("engine select not taken in init");
	ext_hold_a: assert property (safing_state_machine_state != SSM_INIT &&
		!safing_state_machine_reset |=> $stable(external_engine_sel))
		else $error("engine select changed outside init");
	arm_map_a: assert property (!external_engine_sel && !$past(external_engine_sel) &&
		!$past(safing_state_machine_reset) && !$past(safing_state_machine_reset, 2) |->
		internal_arm_signal == arm_map($past(record_armed)))
		else $error("arm signal not the OR of its records");
	arm_cause_a: assert property ((record_armed & ~$past(record_armed) &
		~(positive_arm_result | negative_arm_result)) == '0)
		else $error("record armed without event");
	res_once_a: assert property (!$past(safing_state_machine_reset) |->
		((positive_arm_result ^ $past(positive_arm_result)) &
		~(compare_done_register & ~$past(compare_done_register))) == '0)
		else $error("result changed without a first match");

	// Main scenarios reached
	cover property (compare_done_register != '0);
	cover property (internal_arm_signal != '0);
	cover property (compare_done_read && compare_done_register != '0);
endmodule

bind ssmd_monitor ssmd_chk #(.DWELL_TICK(DWELL_TICK)) u_chk (
	.clk                        (clk),
	.arst_n                     (arst_n),
	.safing_state_machine_state (safing_state_machine_state),
	.safing_state_machine_reset (safing_state_machine_reset),
	.rec_cfg_in                 (rec_cfg_in),
	.external_engine_in         (external_engine_in),
	.compare_done_read          (compare_done_read),
	.compare_done_register      (compare_done_register),
	.positive_arm_result        (positive_arm_result),
	.negative_arm_result        (negative_arm_result),
	.record_armed               (record_armed),
	.internal_arm_signal        (internal_arm_signal),
	.external_engine_sel        (external_engine_sel)
);
`default_nettype wire

// ==== ssmd_link_model.sv ====
// Behavioural model of the monitored sensor bus: controller plus sensors.
// Assumes callers leave a gap of several system clocks between frames.
`timescale 1ns/1ps
`default_nettype none

module ssmd_link_model (
	output logic       sclk,
	output logic [4:0] cs_n,
	output logic       mosi,
	output logic       miso
);
	// Idle bus: clock still, all selects high
	initial
	begin
		sclk = 1'b0;
		cs_n = 5'h1f;
		mosi = 1'b0;
		miso = 1'b0;
	end

	// One 32-bit frame, MSB first, data set up before each rising edge
	task automatic frame(input int cs, input logic [31:0] req, input logic [31:0] rsp);
		#7 cs_n[cs] = 1'b0;
		#80;
		for (int i = 31; i >= 0; i--)
		begin
			mosi = req[i];
			miso = rsp[i];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		#80 cs_n[cs] = 1'b1;
		// Released lines show the inverse of their last bit
		mosi = ~mosi;
		miso = ~miso;
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the safing monitor decoder.
// Assumes the link model in ssmd_link_model.sv and the bound port checker.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import ssmd_pkg::*;

	logic                       clk;
	logic                       arst_n;
	logic                       sclk;
	logic [4:0]                 cs_n;
	logic                       mosi;
	logic                       miso;
	ssmd_ssm_t                  state;
	logic                       sreset;
	logic                       sync;
	ssmd_rec_cfg_t [NREC-1:0]   cfg;
	logic [NREC-1:0]            en;
	logic                       ext_in;
	logic                       rd;
	logic [NREC-1:0]            done;
	logic [NREC-1:0]            pos;
	logic [NREC-1:0]            neg;
	logic [NREC-1:0]            armed;
	logic [NARM-1:0]            iarm;
	logic                       ext_sel;
	int                         failures;
	int                         total_checks;
	localparam logic [31:0]     REQ = 32'h1200_0000;

	ssmd_monitor #(.DWELL_TICK(2)) DUT (
		.clk                         (clk),
		.arst_n                      (arst_n),
		.spi_link_clk                (sclk),
		.sensor_bus_chip_select_n    (cs_n[0]),
		.extra_monitor_chip_select_n (cs_n[4:1]),
		.monitored_request_line      (mosi),
		.monitored_sensor_reply_line (miso),
		.safing_state_machine_state  (state),
		.safing_state_machine_reset  (sreset),
		.sample_sync_event           (sync),
		.rec_cfg_in                  (cfg),
		.rec_enable_in               (en),
		.external_engine_in          (ext_in),
		.compare_done_read           (rd),
		.compare_done_register       (done),
		.positive_arm_result         (pos),
		.negative_arm_result         (neg),
		.record_armed                (armed),
		.internal_arm_signal         (iarm),
		.external_engine_sel         (ext_sel)
	);

	ssmd_link_model lm (
		.sclk (sclk),
		.cs_n (cs_n),
		.mosi (mosi),
		.miso (miso)
	);

	// System clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask

	// One record: fixed request match, reply top byte match, long dwell
	task automatic set_rec(input int i, input int cs, input logic inf, input logic lng,
		input logic [7:0] rt, input logic [31:0] m, input logic [31:0] th,
		input logic [1:0] a, input logic cb, input logic le);
		cfg[i] = '0;
		cfg[i].req_mask = 32'hff00_0000;
		cfg[i].req_target = REQ;
		cfg[i].rsp_mask = 32'hff00_0000;
		cfg[i].rsp_target = {rt, 24'h0};
		cfg[i].record_extract_mask = m;
		cfg[i].event_threshold = th;
		cfg[i].long_rec = lng;
		cfg[i].in_frame = inf;
		cfg[i].cs_sel = 3'(cs);
		cfg[i].arm_signal_select = a;
		cfg[i].dwell = 8'hc8;
		cfg[i].comb = cb;
		cfg[i].range_check_enable = le;
	endtask

	// Frame, then the decode walk plus two spare cycles
	task automatic xfer(input int cs, input logic [31:0] req, input logic [31:0] rsp);
		lm.frame(cs, req, rsp);
		step(8);
	endtask

	task automatic rd_done;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		step(1);
	endtask

	task automatic finish_test;
		$display("Checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#1000000;
		failures++;
		finish_test;
	end

	// Test sequence
	initial
	begin
		failures = 0;
		total_checks = 0;
		arst_n = 1'b0;
		state = SSM_INIT;
		sreset = 1'b0;
		sync = 1'b0;
		en = '0;
		ext_in = 1'b0;
		rd = 1'b0;
		cfg = '0;
		set_rec(0, 0, 1, 0, 8'h34, 32'h0000ffff, 48, 1, 0, 0);
		set_rec(1, 1, 0, 1, 8'h56, 32'h00ffffff, 100, 0, 0, 0);
		set_rec(2, 0, 1, 0, 8'h34, 32'h0000ffff, 10, 2, 0, 1);
		set_rec(3, 0, 1, 0, 8'h34, 32'h0000ffff, 10, 3, 0, 0);
		set_rec(4, 2, 1, 0, 8'h7a, 32'h0000ffff, 48, 0, 1, 0);
		set_rec(5, 2, 1, 0, 8'h7b, 32'h0000ffff, 24, 0, 1, 0);
		set_rec(6, 3, 1, 0, 8'h34, 32'h000000ff, 48, 3, 0, 1);
		cfg[6].range_check_select = 1'b1;
		cfg[6].long_frame_field_select = 1'b1;
		repeat (16) @(posedge clk);
		#2 arst_n = 1'b1;
		step(2);
		chk("done", 32'h0, 32'(done));
		chk("ext_sel", 32'h0, 32'(ext_sel));
		state = SSM_DIAG;
		en = 16'h0077;
		sync = 1'b1;
		step(1);
		sync = 1'b0;
		step(1);
		xfer(0, REQ, 32'h3400_0032);
		chk("done", 32'h0, 32'(done));
		$display("Test setup finished");
		en = 16'h003f;
		state = SSM_SAFING;
		step(1);
		xfer(0, REQ, 32'h3400_0032);
		chk("done", 32'h5, 32'(done));
		chk("pos", 32'h5, 32'(pos));
		chk("armed", 32'h5, 32'(armed));
		chk("iarm", 32'h6, 32'(iarm));
		xfer(0, REQ, 32'h3400_ffce);
		chk("neg", 32'h0, 32'(neg));
		rd_done;
		chk("done", 32'h0, 32'(done));
		xfer(0, REQ, 32'h3400_ffce);
		chk("neg", 32'h5, 32'(neg));
		rd_done;
		xfer(0, REQ, 32'h3400_00c8);
		chk("done", 32'h1, 32'(done));
		$display("Test short records finished");
		rd_done;
		xfer(0, REQ, 32'h0);
		xfer(1, 32'h0, 32'h5600_0100);
		chk("done", 32'h0, 32'(done));
		xfer(1, REQ, 32'h0);
		xfer(1, 32'h0, 32'h5600_0100);
		chk("done", 32'h2, 32'(done));
		chk("pos", 32'h2, 32'(pos & 16'h0002));
		rd_done;
		xfer(2, REQ, 32'h7a00_000c);
		chk("done", 32'h0, 32'(done));
		xfer(2, REQ, 32'h7b00_0032);
		chk("done", 32'h30, 32'(done));
		chk("pos", 32'h10, 32'(pos & 16'h0030));
		chk("neg", 32'h20, 32'(neg & 16'h0030));
		xfer(3, REQ, 32'h34c8_0005);
		chk("done", 32'h40, 32'(done & 16'h0040));
		chk("pos", 32'h40, 32'(pos & 16'h0040));
		chk("iarm", 32'h8, 32'(iarm & 4'h8));
		$display("Test long and paired records finished");
		sreset = 1'b1;
		step(1);
		sreset = 1'b0;
		step(3);
		chk("done", 32'h0, 32'(done));
		chk("armed", 32'h0, 32'(armed));
		chk("iarm", 32'h0, 32'(iarm));
		state = SSM_INIT;
		ext_in = 1'b1;
		step(2);
		chk("ext_sel", 32'h1, 32'(ext_sel));
		state = SSM_DIAG;
		ext_in = 1'b0;
		step(2);
		chk("ext_sel", 32'h1, 32'(ext_sel));
		$display("Test reset and engine finished");
		finish_test;
	end
endmodule
`default_nettype wire
